// file: verilog/cell_balance_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the balance block
// Assumes: 24-bit command word = rw, page[2:0], addr[5:0], data[13:0], msb first
// Notes: definitions only
`ifndef CELL_BALANCE_CONSTS_SVH
`define CELL_BALANCE_CONSTS_SVH

`define FRAME_BITS 24
`define DATA_BITS 14
`define PAGE_CFG 3'h2
`define PAGE_CMD 3'h3
`define ADDR_SETUP 6'h13
`define ADDR_MASK 6'h14
`define ADDR_TIME 6'h15
`define ADDR_DEV_SETUP 6'h19
`define ADDR_VAL_BASE 6'h20
`define ADDR_VAL_LAST 6'h37
`define ADDR_CMD_ENABLE 6'h10
`define ADDR_CMD_INHIBIT 6'h11
`define ENABLE_DATA 14'h0000

`define MODE_LSB 0
`define WAIT_LSB 2
`define PTR_LSB 5
`define ON_BIT 9
`define DUR_LSB 7
`define SUSPEND_BIT 7

`define SETUP_RESET 14'h0000
`define TIME_RESET 14'h0000
`define DEV_SETUP_RESET 14'h0000

`define SLOT_MANUAL 4'h0
`define SLOT_FIRST_AUTO 4'h1

// one duration code step is 20 s: code 3 gives 1 min, code 15 gives 5 min
`define SEC_PER_DUR_CODE 12'd20
`define CLK_HZ 100000000
`define TICK_PERIOD_S 1

`endif

// file: verilog/cell_balance_pkg.sv
// Purpose: types shared by the balance control files
// Assumes: nothing
// Notes: numeric constants live in cell_balance_consts.svh
package cell_balance_pkg;

    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_MANUAL = 2'b01,
        MODE_TIMED = 2'b10,
        MODE_AUTO = 2'b11
    } bal_mode_t;

    // gray along idle -> on -> wait -> on
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ON = 2'b01,
        ST_WAIT = 2'b11
    } bal_state_t;

endpackage

// file: verilog/frame_rx.sv
// Purpose: link-side shifter for 24-bit command words on the serial link clock
// Assumes: cs_n high between words; sclk only runs inside a word
// Notes: completed word is handed over by a toggle; resp must be stable during a word
`timescale 1ns/10ps
`include "cell_balance_consts.svh"
module frame_rx (
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic srst,
    input wire logic [13:0] resp,
    output logic miso,
    output logic [23:0] word,
    output logic word_tgl
);
    logic [4:0] cnt_r;
    logic [22:0] shift_r;
    wire last_bit = (cnt_r == 5'(`FRAME_BITS - 1));
    wire data_phase = (cnt_r >= 5'd9) && (cnt_r < 5'(`FRAME_BITS - 1));
    wire [4:0] resp_idx = 5'd22 - cnt_r;

    // the word ends with cs_n, so cs_n clears the bit count even with sclk stopped
    always_ff @(posedge sclk or posedge cs_n or posedge srst) begin
        if (cs_n || srst) begin
            cnt_r <= 5'h00;
            shift_r <= 23'h000000;
            miso <= 1'b0;
        end else begin
            if (!last_bit) begin
                cnt_r <= cnt_r + 5'h01;
            end
            shift_r <= {shift_r[21:0], mosi};
            miso <= data_phase ? resp[resp_idx[3:0]] : 1'b0;
        end
    end

    // word stays until the next complete word, long enough for the core to sample it
    always_ff @(posedge sclk or posedge srst) begin
        if (srst) begin
            word <= 24'h000000;
            word_tgl <= 1'b0;
        end else if (!cs_n && last_bit) begin
            word <= {shift_r, mosi};
            word_tgl <= ~word_tgl;
        end
    end
endmodule

// file: verilog/sec_tick.sv
// Purpose: one-cycle tick every CYCLES clocks, restartable
// Assumes: CYCLES of at least 2
// Notes: restart realigns the second boundary to the start of a phase
`timescale 1ns/10ps
module sec_tick #(
    parameter int unsigned CYCLES = 100000000
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic restart,
    output logic tick
);
    localparam int W = $clog2(CYCLES);
    logic [W-1:0] cnt_r;
    wire wrap = (cnt_r == W'(CYCLES - 1));

    always_ff @(posedge clk) begin
        if (srst || restart) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else begin
            cnt_r <= wrap ? '0 : cnt_r + W'(1);
            tick <= wrap;
        end
    end
endmodule

// file: verilog/cell_balance_control.sv
// Purpose: cell drain switch control for 12 cells: manual, timed and auto balancing
// Assumes: command words arrive on the serial link; measure_active from same-clock logic
// Notes: read answers shift out during the word that follows the read
//
// Contract
// - mode code 01 is manual balancing, code 10 is timed balancing.
// - mode code 11 is automatic balancing.
// - setup register page 2 addr 0x13: mode, wait, pointer, balance_on.
// - 12-bit drain mask at page 2 addr 0x14, bit n-1 drives cell n.
// - page 3 addr 0x10 command with zero data starts balancing.
// - writing balance_on as one also starts balancing.
// - manual mode holds masked switches on until balancing stops.
// - clearing balance_on or inhibit command page 3 addr 0x11 stops balancing.
// - timed mode switches everything off once the duration elapses.
// - duration code sits in bits 13:7 of page 2 addr 0x15.
// - duration code 3 means one minute, code 15 five minutes.
// - pointer slot 0 holds the mask for manual and timed modes.
// - auto mode applies slots 1, 2, 3 on successive cycles.
// - auto mode inserts a switch-off wait between cycles.
// - wait select code 100 gives an eight second wait.
// - 28-bit balance values in register pairs from addr 0x20 onward.
// - balancing is suspended during measurement when configured.
// - suspend flag is bit 7 of page 2 addr 0x19.
`timescale 1ns/10ps
`include "cell_balance_consts.svh"
module cell_balance_control
    import cell_balance_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `CLK_HZ * `TICK_PERIOD_S,
    parameter int CELLS = 12
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic measure_active,
    output logic miso,
    output logic [CELLS-1:0] drain_en,
    output logic balance_active
);
    logic [23:0] rx_word;
    logic rx_tgl;
    logic tgl_s1_r, tgl_s2_r, tgl_s3_r;
    logic sec_tick_w;
    bal_mode_t mode_r;
    logic [2:0] wait_sel_r;
    logic [3:0] ptr_r;
    logic on_r, on_nxt;
    logic [6:0] wdog_r, dur_code_r;
    logic [13:0] dev_setup_r, resp_r, rd_data;
    logic [CELLS-1:0] mask_mem [16];
    logic [27:0] bal_val [CELLS];
    logic [CELLS-1:0] val_left, drain_r, sel_mask;
    bal_state_t st_r, st_nxt;
    logic [11:0] sec_left_r, sec_nxt;
    logic [3:0] slot_r, slot_nxt;
    logic hw_done;
    function automatic logic reg_hit(input logic [2:0] pg, input logic [5:0] ad,
                                     input logic [2:0] p, input logic [5:0] a);
        return (pg == p) && (ad == a);
    endfunction
    function automatic logic [11:0] wait_seconds(input logic [2:0] sel);
        return (sel == 3'h0) ? 12'h000 : (12'h001 << (sel - 3'h1));
    endfunction
    frame_rx u_rx (
        .sclk(sclk),
        .cs_n(cs_n),
        .mosi(mosi),
        .srst(srst),
        .resp(resp_r),
        .miso(miso),
        .word(rx_word),
        .word_tgl(rx_tgl)
    );

    // the word is held stable from its toggle until the next word ends
    always_ff @(posedge clk) begin
        if (srst) begin
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            tgl_s3_r <= 1'b0;
        end else begin
            tgl_s1_r <= rx_tgl;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
        end
    end

    wire frame_stb = tgl_s2_r ^ tgl_s3_r;
    wire f_rw = rx_word[23];
    wire [2:0] f_page = rx_word[22:20];
    wire [5:0] f_addr = rx_word[19:14];
    wire [13:0] f_data = rx_word[13:0];

    // decode of the command word
    wire wr_any = frame_stb && f_rw;
    wire wr_setup = wr_any && reg_hit(f_page, f_addr, `PAGE_CFG, `ADDR_SETUP);
    wire wr_mask = wr_any && reg_hit(f_page, f_addr, `PAGE_CFG, `ADDR_MASK);
    wire wr_time = wr_any && reg_hit(f_page, f_addr, `PAGE_CFG, `ADDR_TIME);
    wire wr_dev = wr_any && reg_hit(f_page, f_addr, `PAGE_CFG, `ADDR_DEV_SETUP);
    wire in_val = (f_page == `PAGE_CFG) && (f_addr >= `ADDR_VAL_BASE)
                  && (f_addr <= `ADDR_VAL_LAST);
    wire wr_val = wr_any && in_val;
    wire [5:0] val_off = f_addr - `ADDR_VAL_BASE;
    wire [3:0] val_cell = val_off[4:1];
    wire val_hi = val_off[0];
    wire cmd_enable = frame_stb && !f_rw && (f_data == `ENABLE_DATA)
                      && reg_hit(f_page, f_addr, `PAGE_CMD, `ADDR_CMD_ENABLE);
    wire cmd_inhibit = frame_stb && !f_rw
                       && reg_hit(f_page, f_addr, `PAGE_CMD, `ADDR_CMD_INHIBIT);
    wire rd_req = frame_stb && !f_rw && (f_page == `PAGE_CFG);

    // start beats any stop arriving in the same cycle in on_r, but a coinciding hw_done still sends the state to idle
    wire start = cmd_enable || (wr_setup && f_data[`ON_BIT]);
    wire stop = cmd_inhibit || (wr_setup && !f_data[`ON_BIT]) || hw_done;
    assign on_nxt = start ? 1'b1 : (stop ? 1'b0 : on_r);

    // a setup write may carry the mode together with the enable
    wire [1:0] eff_mode = wr_setup ? f_data[`MODE_LSB +: 2] : mode_r;
    wire [11:0] dur_secs = 12'(12'(dur_code_r) * `SEC_PER_DUR_CODE);
    wire [11:0] wait_secs = wait_seconds(wait_sel_r);
    wire [3:0] slot_inc = slot_r + 4'h1;
    wire [3:0] next_slot = (slot_r == 4'hf || mask_mem[slot_inc] == '0)
                           ? `SLOT_FIRST_AUTO : slot_inc;
    wire all_spent = (val_left == '0);
    wire suspend = dev_setup_r[`SUSPEND_BIT] && measure_active;
    wire is_auto = (mode_r == MODE_AUTO);
    wire is_timed = (mode_r == MODE_TIMED);
    wire dec_en = sec_tick_w && (st_r == ST_ON) && is_auto && on_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_r <= MODE_OFF;
            wait_sel_r <= 3'h0;
            ptr_r <= 4'h0;
            on_r <= 1'b0;
        end else begin
            if (wr_setup) begin
                mode_r <= bal_mode_t'(f_data[`MODE_LSB +: 2]);
                wait_sel_r <= f_data[`WAIT_LSB +: 3];
                ptr_r <= f_data[`PTR_LSB +: 4];
            end
            on_r <= on_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wdog_r <= 7'(`TIME_RESET);
            dur_code_r <= 7'(`TIME_RESET >> `DUR_LSB);
            dev_setup_r <= `DEV_SETUP_RESET;
            resp_r <= 14'h0000;
        end else begin
            if (wr_time) begin
                dur_code_r <= f_data[`DUR_LSB +: 7];
                wdog_r <= f_data[6:0];
            end
            if (wr_dev) begin
                dev_setup_r <= f_data;
            end
            if (rd_req) begin
                resp_r <= rd_data;
            end
        end
    end

    // the pointer picks which slot a mask write lands in
    generate
        for (genvar s = 0; s < 16; s++) begin : g_slot
            always_ff @(posedge clk) begin
                if (srst) begin
                    mask_mem[s] <= '0;
                end else if (wr_mask && ptr_r == 4'(s)) begin
                    mask_mem[s] <= f_data[CELLS-1:0];
                end
            end
        end
    endgenerate

    // a host write of a value wins over the count-down of that cell
    generate
        for (genvar i = 0; i < CELLS; i++) begin : g_cell
            assign val_left[i] = (bal_val[i] != 28'h0);
            always_ff @(posedge clk) begin
                if (srst) begin
                    bal_val[i] <= 28'h0;
                end else if (wr_val && val_cell == 4'(i)) begin
                    if (val_hi) begin
                        bal_val[i][27:14] <= f_data;
                    end else begin
                        bal_val[i][13:0] <= f_data;
                    end
                end else if (dec_en && drain_r[i] && val_left[i]) begin
                    bal_val[i] <= bal_val[i] - 28'h1;
                end
            end
        end
    endgenerate

    always_comb begin
        rd_data = 14'h0000;
        if (f_addr == `ADDR_SETUP) begin
            rd_data = {4'h0, on_r, ptr_r, wait_sel_r, mode_r};
        end else if (f_addr == `ADDR_MASK) begin
            rd_data = 14'(mask_mem[ptr_r]);
        end else if (f_addr == `ADDR_TIME) begin
            rd_data = {dur_code_r, wdog_r};
        end else if (f_addr == `ADDR_DEV_SETUP) begin
            rd_data = dev_setup_r;
        end else if (in_val) begin
            rd_data = val_hi ? bal_val[val_cell][27:14] : bal_val[val_cell][13:0];
        end
    end

    always_comb begin
        st_nxt = st_r;
        sec_nxt = sec_left_r;
        slot_nxt = slot_r;
        hw_done = 1'b0;
        case (st_r)
            ST_IDLE: begin
                if (start) begin
                    st_nxt = ST_ON;
                    sec_nxt = dur_secs;
                    slot_nxt = (eff_mode == MODE_AUTO) ? `SLOT_FIRST_AUTO : `SLOT_MANUAL;
                end
            end
            ST_ON: begin
                if (!on_r) begin
                    st_nxt = ST_IDLE;
                end else if (is_auto && all_spent) begin
                    hw_done = 1'b1;
                    st_nxt = ST_IDLE;
                end else if ((is_timed || is_auto) && sec_tick_w) begin
                    if (sec_left_r > 12'h001) begin
                        sec_nxt = sec_left_r - 12'h001;
                    end else if (is_timed) begin
                        hw_done = 1'b1;
                        st_nxt = ST_IDLE;
                    end else if (wait_secs == 12'h000) begin
                        slot_nxt = next_slot;
                        sec_nxt = dur_secs;
                    end else begin
                        st_nxt = ST_WAIT;
                        sec_nxt = wait_secs;
                    end
                end
            end
            ST_WAIT: begin
                if (!on_r) begin
                    st_nxt = ST_IDLE;
                end else if (sec_tick_w) begin
                    if (sec_left_r > 12'h001) begin
                        sec_nxt = sec_left_r - 12'h001;
                    end else begin
                        st_nxt = ST_ON;
                        slot_nxt = next_slot;
                        sec_nxt = dur_secs;
                    end
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= ST_IDLE;
            sec_left_r <= 12'h000;
            slot_r <= `SLOT_MANUAL;
        end else begin
            st_r <= st_nxt;
            sec_left_r <= sec_nxt;
            slot_r <= slot_nxt;
        end
    end

    // the second counter restarts with every phase so each phase lasts whole seconds
    sec_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .clk(clk),
        .srst(srst),
        .restart(st_nxt != st_r || start),
        .tick(sec_tick_w)
    );
    always_comb begin
        case (mode_r)
            MODE_MANUAL: sel_mask = mask_mem[`SLOT_MANUAL];
            MODE_TIMED: sel_mask = mask_mem[`SLOT_MANUAL];
            MODE_AUTO: sel_mask = mask_mem[slot_r] & val_left;
            default: sel_mask = '0;
        endcase
    end
    wire [CELLS-1:0] drain_nxt = (st_r == ST_ON && on_r && !suspend) ? sel_mask : '0;
    always_ff @(posedge clk) begin
        if (srst) begin
            drain_r <= '0;
            balance_active <= 1'b0;
        end else begin
            drain_r <= drain_nxt;
            balance_active <= on_nxt;
        end
    end
    assign drain_en = drain_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_enable_starts;
        cmd_enable |=> on_r ##1 (st_r == ST_ON);
    endproperty
    a_enable_starts: assert property (p_enable_starts) else $error("enable ignored");
    property p_inhibit_stops;
        (cmd_inhibit && !start) |=> !on_r ##1 (drain_r == '0);
    endproperty
    a_inhibit_stops: assert property (p_inhibit_stops) else $error("inhibit ignored");
    property p_setup_on_bit;
        (wr_setup && f_data[`ON_BIT]) |=> (balance_active && on_r);
    endproperty
    a_setup_on_bit: assert property (p_setup_on_bit) else $error("on bit ignored");
    property p_suspend_dark;
        (suspend && $past(suspend)) |-> ##1 (drain_r == '0);
    endproperty
    a_suspend_dark: assert property (p_suspend_dark) else $error("drain in measure");
    property p_wait_dark;
        (st_r == ST_WAIT) ##1 (st_r == ST_WAIT) |-> (drain_r == '0);
    endproperty
    a_wait_dark: assert property (p_wait_dark) else $error("drain in wait gap");
    property p_timed_end;
        (st_r == ST_ON && is_timed && on_r && sec_tick_w && sec_left_r <= 12'h001
         && !frame_stb) |=> !on_r ##1 (drain_r == '0);
    endproperty
    a_timed_end: assert property (p_timed_end) else $error("timed run overran");
    property p_manual_hold;
        (st_r == ST_ON && mode_r == MODE_MANUAL && on_r && !suspend && !frame_stb)
            |=> (drain_r == $past(mask_mem[`SLOT_MANUAL]));
    endproperty
    a_manual_hold: assert property (p_manual_hold) else $error("manual mask lost");
    property p_auto_dec;
        (dec_en && drain_r[0] && val_left[0] && !frame_stb)
            |=> (bal_val[0] == $past(bal_val[0]) - 28'h1);
    endproperty
    a_auto_dec: assert property (p_auto_dec) else $error("value not counted");
    property p_slot_wrap;
        (st_r == ST_WAIT && st_nxt == ST_ON) |=> (slot_r != `SLOT_MANUAL
                                                  && mask_mem[slot_r] != '0
                                                  || slot_r == `SLOT_FIRST_AUTO);
    endproperty
    a_slot_wrap: assert property (p_slot_wrap) else $error("bad auto slot");
    property p_mask_store;
        wr_mask |=> (mask_mem[$past(ptr_r)] == $past(f_data[CELLS-1:0]));
    endproperty
    a_mask_store: assert property (p_mask_store) else $error("mask not stored");

    c_manual_on: cover property (st_r == ST_ON && mode_r == MODE_MANUAL && drain_r != '0);
    c_auto_wait: cover property (st_r == ST_ON && is_auto ##1 st_r == ST_WAIT);
    c_auto_done: cover property (hw_done && is_auto);
endmodule

// file: sim/spi_host_model.sv
// Purpose: host side of the serial link, sends 24-bit words and gathers read answers
// Assumes: sclk period 64 ns, idle low, running only inside a word
// Notes: the answer to a read arrives during the following word
`timescale 1ns/10ps
module spi_host_model (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    logic [13:0] ans;
    logic prev_rd;
    event ans_done;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        ans = 14'h0000;
        prev_rd = 1'b0;
    end
    // stand-alone link: no device address and no crc around the word
    task automatic send(input logic [23:0] w);
        #7.3;
        cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            mosi = w[i];
            #32;
            if (i < 14) ans[i] = miso;
            sclk = 1'b1;
            #32;
            sclk = 1'b0;
        end
        #32;
        cs_n = 1'b1;
        // released line has no pull, so show the inverse rather than a stale level
        mosi = ~mosi;
        if (prev_rd) ->ans_done;
        prev_rd = !w[23] && w[22:20] == 3'h2;
        #1536;
    endtask
endmodule

// file: sim/tb.sv
// Purpose: self-checking bench for the cell balance control block
// Assumes: one second shortened to TICK clocks
// Notes: every drain change is matched in order against a queue of expected masks
`timescale 1ns/10ps
`include "cell_balance_consts.svh"
module tb;
    localparam int TICK = 20;
    logic clk = 1'b0;
    logic srst = 1'b0;
    logic measure_active = 1'b0;
    wire sclk, cs_n, mosi, miso, balance_active;
    wire [11:0] drain_en;
    int mismatches = 0;
    int checks_done = 0;
    int cyc = 0;
    int last_cyc = 0;
    logic [11:0] last_drain = 12'h000;
    logic [11:0] exp_drain[$];
    logic [13:0] exp_rd[$];
    int gaps[$];
    logic [11:0] m;
    logic [2:0] wait_any;

    always #5 clk = ~clk;

    cell_balance_control #(.TICK_CYCLES(TICK), .CELLS(12)) dut_u (.clk(clk), .srst(srst),
        .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .measure_active(measure_active),
        .miso(miso), .drain_en(drain_en), .balance_active(balance_active));
    spi_host_model host_u (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

    task automatic complete_run();
        if (mismatches == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input string n, input logic [13:0] e, input logic [13:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    // timers start on tick boundaries, so two ticks of slack
    task automatic cmp_gap(input string n, input int e, input int g);
        checks_done++;
        if (g < e - 2 * TICK || g > e + 2 * TICK) begin
            mismatches++;
            $display("mismatch %s expected %0d seen %0d", n, e, g);
        end
    endtask

    always @(negedge clk) begin
        cyc++;
        if (cyc > 60000) begin
            mismatches++;
            complete_run();
        end
        if (!srst && drain_en !== last_drain) begin
            gaps.push_back(cyc - last_cyc);
            last_cyc = cyc;
            last_drain = drain_en;
            if (exp_drain.size() == 0) begin
                cmp("drain_en", 14'h3fff, {2'b00, drain_en});
            end else begin
                cmp("drain_en", {2'b00, exp_drain.pop_front()}, {2'b00, drain_en});
            end
        end
    end

    always begin
        @(host_u.ans_done);
        cmp("read", exp_rd.pop_front(), host_u.ans);
    end

    function automatic logic [23:0] wr(input logic [5:0] a, input logic [13:0] d);
        return {1'b1, `PAGE_CFG, a, d};
    endfunction
    function automatic logic [23:0] rd(input logic [5:0] a);
        return {1'b0, `PAGE_CFG, a, 14'h0000};
    endfunction
    function automatic logic [23:0] cmd(input logic [5:0] a, input logic [13:0] d);
        return {1'b0, `PAGE_CMD, a, d};
    endfunction
    function automatic logic [13:0] setup(input logic [1:0] md, input logic [2:0] wt,
                                         input logic [3:0] p, input logic on);
        return {4'h0, on, p, wt, md};
    endfunction

    task automatic wait_idle(input int lim);
        repeat (lim) begin
            @(negedge clk);
            if (balance_active === 1'b0) break;
        end
        repeat (5) @(negedge clk);
    endtask

    initial begin
        logic [6:0] codes [2] = '{7'h03, 7'h0f};
        int secs [2] = '{60, 300};
        int vals [4] = '{10, 5, 5, 30};
        logic [13:0] slots [4] = '{14'h0009, 14'h0004, 14'h0002, 14'h0000};
        logic [11:0] auto_seq [9] = '{12'h009, 12'h008, 12'h000, 12'h004, 12'h000,
                                      12'h002, 12'h000, 12'h008, 12'h000};
        void'($urandom(32'hdfea));
        m = 12'($urandom()) | 12'h001;
        wait_any = 3'($urandom());
        // a real rising edge so the link-side flops see the reset
        #1 srst = 1'b1;
        repeat (10) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        cmp("drain_en", 14'h0000, {2'b00, drain_en});
        cmp("balance_active", 14'h0000, {13'h0000, balance_active});
        cmp("miso", 14'h0000, {13'h0000, miso});
        host_u.send(wr(`ADDR_SETUP, setup(2'b01, wait_any, 4'h0, 1'b0)));
        host_u.send(wr(`ADDR_MASK, 14'h0451));
        host_u.send(cmd(`ADDR_CMD_ENABLE, 14'($urandom()) | 14'h0001));
        exp_drain.push_back(12'h451);
        host_u.send(cmd(`ADDR_CMD_ENABLE, 14'h0000));
        cmp("balance_active", 14'h0001, {13'h0000, balance_active});
        exp_drain.push_back(12'h000);
        host_u.send(cmd(`ADDR_CMD_INHIBIT, 14'h0000));
        host_u.send(wr(`ADDR_MASK, {2'b00, m}));
        exp_drain.push_back(m);
        host_u.send(wr(`ADDR_SETUP, setup(2'b01, wait_any, 4'h0, 1'b1)));
        exp_rd.push_back(setup(2'b01, wait_any, 4'h0, 1'b1));
        host_u.send(rd(`ADDR_SETUP));
        exp_rd.push_back({2'b00, m});
        host_u.send(rd(`ADDR_MASK));
        exp_rd.push_back(14'h0000);
        host_u.send(rd(6'h38 | 6'($urandom() % 8)));
        exp_rd.push_back(14'h0000);
        host_u.send(rd(`ADDR_TIME));
        host_u.send(wr(`ADDR_DEV_SETUP, 14'h0080));
        exp_drain.push_back(12'h000);
        @(negedge clk);
        measure_active = 1'b1;
        repeat (10) @(negedge clk);
        exp_drain.push_back(m);
        measure_active = 1'b0;
        repeat (10) @(negedge clk);
        exp_drain.push_back(12'h000);
        host_u.send(wr(`ADDR_SETUP, setup(2'b01, wait_any, 4'h0, 1'b0)));
        // mode 00 is on but drives nothing, although slot 0 still holds a mask
        host_u.send(wr(`ADDR_SETUP, setup(2'b00, wait_any, 4'h0, 1'b1)));
        cmp("balance_active", 14'h0001, {13'h0000, balance_active});
        for (int k = 0; k < 2; k++) begin
            host_u.send(wr(`ADDR_TIME, {codes[k], 7'h7f}));
            host_u.send(wr(`ADDR_SETUP, setup(2'b10, wait_any, 4'h0, 1'b0)));
            host_u.send(wr(`ADDR_MASK, 14'h0082));
            gaps.delete();
            exp_drain.push_back(12'h082);
            exp_drain.push_back(12'h000);
            host_u.send(cmd(`ADDR_CMD_ENABLE, 14'h0000));
            wait_idle(secs[k] * TICK + 200);
            cmp_gap("timed on", secs[k] * TICK, gaps[1]);
            cmp("balance_active", 14'h0000, {13'h0000, balance_active});
        end
        host_u.send(wr(`ADDR_TIME, {7'h01, 7'h7f}));
        // balance values come from the host's own charge arithmetic
        for (int n = 0; n < 4; n++) begin
            host_u.send(wr(6'(`ADDR_VAL_BASE + 2 * n), 14'(vals[n])));
            host_u.send(wr(6'(`ADDR_VAL_BASE + 2 * n + 1), 14'h0000));
        end
        for (int s = 1; s < 5; s++) begin
            host_u.send(wr(`ADDR_SETUP, setup(2'b11, 3'h4, 4'(s), 1'b0)));
            host_u.send(wr(`ADDR_MASK, slots[s - 1]));
        end
        gaps.delete();
        foreach (auto_seq[i]) exp_drain.push_back(auto_seq[i]);
        host_u.send(cmd(`ADDR_CMD_ENABLE, 14'h0000));
        wait_idle(4000);
        cmp_gap("first cell run", 10 * TICK, gaps[1]);
        cmp_gap("wait gap", 8 * TICK, gaps[3]);
        cmp("balance_active", 14'h0000, {13'h0000, balance_active});
        cmp("pending", 14'h0000, 14'(exp_drain.size() + exp_rd.size()));
        complete_run();
    end
endmodule
